// [src/sleep_port_clock_gating.sv]
// Run, sleep and deep-sleep clock gating of eight ports with AHB-Lite access
`timescale 1ns/1ps
`include "port_gate_consts.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] Bits 7..0 enable the clock of ports H..A; set means clocked.
// [RQ2] A clear gating bit stops the clock to that port.
// [RQ3] Access to an unclocked port is answered with a bus fault.
// [RQ4] All gating bits reset to zero, every port unclocked.
// [RQ5] Bits 31..8 are read-only, read zero, ignore writes.
// [RQ6] Software preserves reserved bits and never relies on their value.
// [RQ7] Software enables each port it needs; none is on by default.
// [RQ8] Sleep register acts in Sleep; same-layout registers for run, deep sleep.
// [RQ9] Sleep registers apply only while auto clock gating is enabled.
// [RQ10] Run register at 0x108 holds the same layout, used while running.
// [RQ11] Sleep entry switches enables to sleep value; wake reverts to run.
module sleep_port_clock_gating
#(
  parameter int NPORTS = `PORT_COUNT
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power mode requests from the system
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // Port clock enables and port access faults
  output logic [NPORTS-1:0] port_clk_en,
  input wire logic [NPORTS-1:0] port_access,
  output logic [NPORTS-1:0] port_bus_fault,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  port_gate_pkg::gate_set_t gates;
  logic auto_clock_gating_enable;
  logic [NPORTS-1:0] fault_status;
  logic [NPORTS-1:0] fault_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Mode request synchronisers

  logic sleep_meta;
  logic sleep_sync;
  logic deep_meta;
  logic deep_sync;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      deep_meta <= 1'b0;
      deep_sync <= 1'b0;
    end
    else
    begin
      sleep_meta <= sleep_req;
      sleep_sync <= sleep_meta;
      deep_meta <= deep_sleep_req;
      deep_sync <= deep_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode selection

  port_gate_pkg::power_mode_t mode;
  port_gate_pkg::power_mode_t next_mode;

  always_comb
  begin
    next_mode = port_gate_pkg::mode_run;
    // Without auto gating the run register stays in force in every mode
    if (auto_clock_gating_enable) // [RQ9]
    begin
      if (deep_sync)
        next_mode = port_gate_pkg::mode_deep_sleep;
      else if (sleep_sync)
        next_mode = port_gate_pkg::mode_sleep; // [RQ8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode <= port_gate_pkg::mode_run;
    else
      mode <= next_mode; // [RQ11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port clock enables

  logic [NPORTS-1:0] next_clk_en;

  always_comb
  begin
    next_clk_en = gates.run_gate[NPORTS-1:0]; // [RQ10]
    unique case (mode)
      port_gate_pkg::mode_run:
        next_clk_en = gates.run_gate[NPORTS-1:0];
      port_gate_pkg::mode_sleep:
        next_clk_en = gates.sleep_gate[NPORTS-1:0]; // [RQ8] [RQ11]
      port_gate_pkg::mode_deep_sleep:
        next_clk_en = gates.deep_gate[NPORTS-1:0];
      default:
        next_clk_en = gates.run_gate[NPORTS-1:0];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_clk_en <= '0; // [RQ4]
    else
      port_clk_en <= next_clk_en; // [RQ1] [RQ2]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Faults on accesses to unclocked ports

  logic [NPORTS-1:0] fault_event;

  port_fault_check #(.NPORTS(NPORTS)) u_fault
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_access(port_access),
    .clk_en(port_clk_en),
    .fault(fault_event)
  );

  assign port_bus_fault = fault_event; // [RQ3]

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase

  port_gate_pkg::bus_req_t req;
  logic data_phase;
  logic wr_pending;
  logic rd_pending;
  logic take;

  assign take = hsel & htrans[1] & hready;
  assign wr_pending = data_phase & req.write;
  assign rd_pending = data_phase & ~req.write;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req <= '0;
      data_phase <= 1'b0;
    end
    else
    begin
      data_phase <= take;
      if (take)
      begin
        req.addr <= haddr[`ADDR_DECODE_WIDTH-1:0];
        req.write <= hwrite;
      end
    end
  end

  // Reads take one wait state because hrdata is registered a cycle into the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else if (take & ~hwrite)
      hreadyout <= 1'b0;
    else
      hreadyout <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic wr_cfg;
  logic wr_status;
  logic wr_mask;

  assign wr_run = wr_pending & (req.addr == `RUN_PORT_CLOCK_GATE_OFF);
  assign wr_sleep = wr_pending & (req.addr == `SLEEP_PORT_CLOCK_GATE_OFF);
  assign wr_deep = wr_pending & (req.addr == `DEEP_SLEEP_PORT_CLOCK_GATE_OFF);
  assign wr_cfg = wr_pending & (req.addr == `RUN_CLOCK_CONFIGURATION_OFF);
  assign wr_status = wr_pending & (req.addr == `GATE_FAULT_STATUS_OFF);
  assign wr_mask = wr_pending & (req.addr == `GATE_FAULT_MASK_OFF);

  // Only the low port bits are stored; upper bits of a write are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gates.run_gate <= `PORT_CLOCK_GATE_RESET;
      gates.sleep_gate <= `PORT_CLOCK_GATE_RESET; // [RQ4]
      gates.deep_gate <= `PORT_CLOCK_GATE_RESET;
    end
    else
    begin
      if (wr_run)
        gates.run_gate <= hwdata[`PORT_FIELD_MSB:0]; // [RQ10]
      if (wr_sleep)
        gates.sleep_gate <= hwdata[`PORT_FIELD_MSB:0]; // [RQ1] [RQ5]
      if (wr_deep)
        gates.deep_gate <= hwdata[`PORT_FIELD_MSB:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      auto_clock_gating_enable <= `RUN_CLOCK_CONFIGURATION_RESET;
    else if (wr_cfg)
      auto_clock_gating_enable <= hwdata[`AUTO_CLOCK_GATING_ENABLE_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault_mask <= `GATE_FAULT_MASK_RESET;
    else if (wr_mask)
      fault_mask <= hwdata[NPORTS-1:0];
  end

  // Sticky fault bits: a new fault wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault_status <= '0;
    else if (wr_status)
      fault_status <= (fault_status & ~hwdata[NPORTS-1:0]) | fault_event;
    else
      fault_status <= fault_status | fault_event;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(fault_status & fault_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  logic [31:0] next_rdata;

  // Reserved and unmapped bits read as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (req.addr)
      `RUN_PORT_CLOCK_GATE_OFF:
        next_rdata[`PORT_FIELD_MSB:0] = gates.run_gate;
      `SLEEP_PORT_CLOCK_GATE_OFF:
        next_rdata[`PORT_FIELD_MSB:0] = gates.sleep_gate; // [RQ5]
      `DEEP_SLEEP_PORT_CLOCK_GATE_OFF:
        next_rdata[`PORT_FIELD_MSB:0] = gates.deep_gate;
      `RUN_CLOCK_CONFIGURATION_OFF:
        next_rdata[`AUTO_CLOCK_GATING_ENABLE_BIT] = auto_clock_gating_enable;
      `GATE_FAULT_STATUS_OFF:
        next_rdata[NPORTS-1:0] = fault_status;
      `GATE_FAULT_MASK_OFF:
        next_rdata[NPORTS-1:0] = fault_mask;
      `GATE_MODE_STATUS_OFF:
      begin
        next_rdata[NPORTS-1:0] = port_clk_en;
        next_rdata[`MODE_STATUS_MODE_LSB+1:`MODE_STATUS_MODE_LSB] = mode;
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_pending)
      hrdata <= next_rdata;
  end

endmodule

// [inc/port_gate_consts.svh]
// Offsets, field positions, reset values and widths of the port gating block
`ifndef PORT_GATE_CONSTS_SVH
`define PORT_GATE_CONSTS_SVH

// Register byte offsets
`define RUN_CLOCK_CONFIGURATION_OFF 12'h060
`define RUN_PORT_CLOCK_GATE_OFF 12'h108
`define SLEEP_PORT_CLOCK_GATE_OFF 12'h118
`define DEEP_SLEEP_PORT_CLOCK_GATE_OFF 12'h128
`define GATE_FAULT_STATUS_OFF 12'h140
`define GATE_FAULT_MASK_OFF 12'h144
`define GATE_MODE_STATUS_OFF 12'h148

// Field layout
`define PORT_COUNT 8
`define PORT_FIELD_MSB 7
`define AUTO_CLOCK_GATING_ENABLE_BIT 0
`define MODE_STATUS_MODE_LSB 8
`define ADDR_DECODE_WIDTH 12

// Reset values
`define PORT_CLOCK_GATE_RESET 8'h00
`define RUN_CLOCK_CONFIGURATION_RESET 1'b0
`define GATE_FAULT_MASK_RESET 8'h00

`endif

// [inc/port_gate_pkg.sv]
// Types shared by the port clock gating block
package port_gate_pkg;

  typedef enum logic [1:0]
  {
    mode_run = 2'b00,
    mode_sleep = 2'b01,
    mode_deep_sleep = 2'b10
  } power_mode_t;

  typedef struct packed
  {
    logic [11:0] addr;
    logic write;
  } bus_req_t;

  typedef struct packed
  {
    logic [7:0] run_gate;
    logic [7:0] sleep_gate;
    logic [7:0] deep_gate;
  } gate_set_t;

endpackage

// [src/port_fault_check.sv]
// Per-port bus fault detection for accesses to unclocked ports
`timescale 1ns/1ps
`include "port_gate_consts.svh"

module port_fault_check
#(
  parameter int NPORTS = `PORT_COUNT
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Port accesses and current clock enables
  input wire logic [NPORTS-1:0] port_access,
  input wire logic [NPORTS-1:0] clk_en,
  // One-cycle fault answer per port
  output logic [NPORTS-1:0] fault
);

  genvar i;
  generate
    for (i = 0; i < NPORTS; i++)
    begin : g_port
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          fault[i] <= 1'b0;
        else
          fault[i] <= port_access[i] & ~clk_en[i]; // [RQ3]
      end
    end
  endgenerate

endmodule

// [tb/port_gate_sva.sv]
// Port gating block assertions and their bind
`timescale 1ns/1ps

module port_gate_sva
#(
  parameter int NPORTS = 8
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Modes, ports and interrupt
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [NPORTS-1:0] port_clk_en,
  input wire logic [NPORTS-1:0] port_access,
  input wire logic [NPORTS-1:0] port_bus_fault,
  input wire logic irq
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic taken;
  logic [1:0] req_d;
  logic [3:0] quiet;
  assign taken = hsel && htrans[1] && hready;
  // Cycles since the last transfer or mode pin change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_d <= 2'h0;
      quiet <= 4'h0;
    end
    else
    begin
      req_d <= {sleep_req, deep_sleep_req};
      if (taken || req_d != {sleep_req, deep_sleep_req})
        quiet <= 4'h0;
      else if (quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_gated_fault: assert property (
    port_bus_fault == ($past(port_access) & ~$past(port_clk_en)))
    else $error("fault pulse wrong");
  a_read_wait: assert property (
    taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (
    taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_enable_quiet: assert property (
    quiet >= 4'h6 |-> $stable(port_clk_en))
    else $error("clock enables moved without cause");
  a_reset_gated: assert property (
    $rose(hresetn) |-> port_clk_en == '0 && port_bus_fault == '0 && !irq)
    else $error("outputs not clear after reset");
  a_rdata_hold: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_wait_one: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  c_enable_change: cover property ($changed(port_clk_en));
  c_read: cover property (taken && !hwrite ##2 hrdata != 32'h0);
  c_fault: cover property (port_bus_fault != '0);
  c_irq: cover property ($rose(irq));
endmodule

bind sleep_port_clock_gating port_gate_sva #(.NPORTS(NPORTS)) u_sva
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
  .port_clk_en(port_clk_en), .port_access(port_access),
  .port_bus_fault(port_bus_fault), .irq(irq)
);

// [tb/tb.sv]
// Self-checking bench for the port clock gating block
`timescale 1ns/1ps

module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  logic sleep_req = 1'b0;
  logic deep_sleep_req = 1'b0;
  logic [7:0] port_clk_en, port_bus_fault;
  logic [7:0] port_access = 8'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] exp_q[$];
  logic [7:0] flt_q[$];
  logic irq_q[$];
  logic [7:0] en_q[$];
  logic rd_ph = 1'b0;
  logic ac_ph = 1'b0;
  logic irq_ph = 1'b0;
  logic en_ph = 1'b0;
  int left = 0;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] r, s, d;
  logic [11:0] offs[6] = '{12'h060, 12'h108, 12'h118, 12'h128, 12'h144,
    12'h148};

  always #2.5 hclk = ~hclk;

  sleep_port_clock_gating dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .port_clk_en(port_clk_en), .port_access(port_access),
    .port_bus_fault(port_bus_fault), .irq(irq)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want)
    begin
      mismatches++;
      $display("MISMATCH t=%0t rdata got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_flt(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want)
    begin
      mismatches++;
      $display("MISMATCH t=%0t fault got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_irq(input logic got, input logic want);
    tests_run++;
    if (got !== want)
    begin
      mismatches++;
      $display("MISMATCH t=%0t irq got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_en(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want)
    begin
      mismatches++;
      $display("MISMATCH t=%0t clk_en got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One single word transfer; waits for ready in both phases
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask

  // Let the enables settle, note them for the watcher, then read the status
  task automatic stat(input logic [1:0] m, input logic [7:0] en);
    repeat (7) @(posedge hclk);
    en_q.push_back(en);
    en_ph <= 1'b1;
    @(posedge hclk);
    en_ph <= 1'b0;
    rd(12'h148, {22'h0, m, en});
  endtask

  // Note the interrupt level due once the last write has taken effect
  task automatic irq_note(input logic e);
    repeat (2) @(posedge hclk);
    irq_q.push_back(e);
    irq_ph <= 1'b1;
    @(posedge hclk);
    irq_ph <= 1'b0;
  endtask

  // Pulse port accesses and note the faults due for unclocked ports
  task automatic poke(input logic [7:0] acc, input logic [7:0] en);
    flt_q.push_back(acc & ~en);
    port_access <= acc;
    @(posedge hclk);
    port_access <= 8'h0;
    repeat (2) @(posedge hclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
      chk_rd(hrdata, exp_q.pop_front());
    if (ac_ph)
      chk_flt(port_bus_fault, flt_q.pop_front());
    if (irq_ph)
      chk_irq(irq, irq_q.pop_front());
    if (en_ph)
      chk_en(port_clk_en, en_q.pop_front());
    if (hreadyout)
      rd_ph <= hsel && htrans[1] && !hwrite;
    ac_ph <= |port_access;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    r = $urandom(66575);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (offs[i])
      rd(offs[i], 32'h0);
    poke(8'hff, 8'h00);
    r = $urandom() & 32'hfffffffe;
    s = $urandom();
    d = $urandom();
    xfer(12'h108, 1'b1, r);
    rd(12'h108, {24'h0, r[7:0]});
    xfer(12'h118, 1'b1, 32'hffffff00);
    rd(12'h118, 32'h0);
    xfer(12'h118, 1'b1, s);
    xfer(12'h128, 1'b1, d);
    rd(12'h118, {24'h0, s[7:0]});
    xfer(12'h118, 1'b1, {24'h0, s[7:0] | 8'h01});
    rd(12'h118, {24'h0, s[7:0] | 8'h01});
    xfer(12'h118, 1'b1, {24'h0, s[7:0]});
    xfer(12'h1fc, 1'b1, r);
    rd(12'h1fc, 32'h0);
    xfer(12'h148, 1'b1, ~r);
    rd(12'h148, {24'h0, r[7:0]});
    poke(8'hff, r[7:0]);
    sleep_req <= 1'b1;
    stat(2'b00, r[7:0]);
    poke(8'hff, r[7:0]);
    xfer(12'h060, 1'b1, 32'h1);
    stat(2'b01, s[7:0]);
    poke(8'hff, s[7:0]);
    deep_sleep_req <= 1'b1;
    stat(2'b10, d[7:0]);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    stat(2'b00, r[7:0]);
    xfer(12'h140, 1'b1, 32'hff);
    poke(8'hff, r[7:0]);
    rd(12'h140, {24'h0, ~r[7:0]});
    xfer(12'h144, 1'b1, 32'hff);
    irq_note(1'b1);
    xfer(12'h144, 1'b1, 32'h0);
    irq_note(1'b0);
    xfer(12'h144, 1'b1, 32'hff);
    xfer(12'h140, 1'b1, 32'hff);
    irq_note(1'b0);
    rd(12'h140, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h108, 32'h0);
    stat(2'b00, 8'h00);
    irq_note(1'b0);
    // Let the watcher take the last notes before the verdict
    repeat (4) @(posedge hclk);
    left = exp_q.size() + flt_q.size() + irq_q.size() + en_q.size();
    if (left != 0)
    begin
      mismatches++;
      $display("MISMATCH t=%0t notes left=%h exp=%h", $time, left, 0);
    end
    stop_test();
  end
endmodule
